// >>> rtl/twbpe_regs.svh
// Constants of the two-wire bus protocol engine: status codes, timing, general call address, bit counts.
// Included by the engine; holds definitions only.
`ifndef TWBPE_REGS_SVH
`define TWBPE_REGS_SVH

// Status codes; bit 0 of an acknowledge-bearing code is set on a not-acknowledge
`define TWBPE_ST_NOINFO 8'hff
`define TWBPE_ST_BUSERR 8'h00
`define TWBPE_ST_START 8'h08
`define TWBPE_ST_REPSTART 8'h0c
`define TWBPE_ST_MT_ADDR 8'h10
`define TWBPE_ST_MT_DATA 8'h14
`define TWBPE_ST_ARBLOST 8'h18
`define TWBPE_ST_MR_ADDR 8'h20
`define TWBPE_ST_MR_DATA 8'h24
`define TWBPE_ST_SR_ADDR 8'h30
`define TWBPE_ST_SR_GCALL 8'h34
`define TWBPE_ST_SR_DATA 8'h38
`define TWBPE_ST_SR_STOP 8'h3c
`define TWBPE_ST_ST_ADDR 8'h40
`define TWBPE_ST_ST_DATA 8'h44

// Fixed part of one SCL half period, in clocks (a full period is twice the sum of this and the rate term)
`define TWBPE_HALF_BASE 16'd8
`define TWBPE_GCALL_ADDR 7'h00
`define TWBPE_BITS_PER_PACKET 4'd9
`define TWBPE_BITS_PER_BYTE 4'd8

`endif

// >>> rtl/twbpe_pkg.sv
// Types of the two-wire bus protocol engine.
// Shared by the engine and whatever drives its control ports.
package twbpe_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_LOW = 3'b011,
		ST_HIGH = 3'b010,
		ST_HOLD = 3'b110,
		ST_STOP = 3'b111,
		ST_SLAVE = 3'b101
	} twbpe_state_t;

	typedef struct packed {
		logic startReq;
		logic stopReq;
		logic ackEnable;
	} twbpe_ctrl_t;

	typedef struct packed {
		logic [6:0] address;
		logic generalCallAccept;
	} twbpe_addr_t;

endpackage

// >>> rtl/twbpe_engine.sv
// Two-wire bus protocol engine: master and slave byte engine with event flag and SCL stall.
// Assumes open-drain pads outside (oe high pulls the line low) and software on ref_clk.
//
// Operation
// RULE1: event raises pending flag; status code follows one clock later.
// RULE2: status shows no-information code whenever the flag is clear; here from one clock after it clears.
// RULE3: SCL held low while the flag is set; here only as master or addressed slave.
// RULE4: flag after sending START or repeated START, and after each address byte.
// RULE5: flag when arbitration is lost as master.
// RULE6: flag when addressed by own or general call address, and per data byte.
// RULE7: flag on STOP or repeated START while still addressed as slave.
// RULE8: START or STOP at an illegal place gives bus error and flag.
// RULE9: SDA changes only while SCL is low; one SCL pulse per bit.
// RULE10: START/STOP are SDA edges with SCL high; bus busy between them.
// RULE11: repeated START keeps the bus busy until the next STOP.
// RULE12: address packet: seven bits MSB first, direction bit, acknowledge slot.
// RULE13: addressed slave pulls SDA low in ninth cycle; otherwise leaves it high.
// RULE14: all-zero address is general call, acknowledged only with write bit.
// RULE15: addresses with upper four bits all ones stay unassigned.
// RULE16: data packet is byte plus acknowledge; receiver answers NACK after last.
// RULE17: master makes clock, START and STOP; no START directly followed by STOP.
// RULE18: slave may stretch SCL low; master waits for SCL to rise.
// RULE19: master times SCL high and low from observed line levels.
// RULE20: master compares SDA with driven bit; mismatch means lost arbitration.
// RULE21: after losing, release SDA and check own address as slave.
// RULE22: multi-master software uses identical packet composition.
// RULE23: SCL rate is clock over sixteen plus twice divider times prescale.
// RULE24: writing one clears the flag; no operation starts while it is set.
// RULE25: received addresses compared with own address and, if enabled, general call.
// RULE26: lines driven open-drain only, and sampled through synchronisers.
// RULE27: reset clears flag, releases lines, leaves engine idle and unaddressed.
`include "twbpe_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module twbpe_engine (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ctrlWrite,
	input wire twbpe_pkg::twbpe_ctrl_t ctrl,
	input wire logic [7:0] txData,
	input wire twbpe_pkg::twbpe_addr_t ownAddr,
	input wire logic [7:0] bitRateDivider,
	input wire logic [1:0] ratePrescaleSelect,
	output logic eventPendingFlag,
	output logic [7:0] busStatusCode,
	output logic [7:0] rxData,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	import twbpe_pkg::*;

	// Prescale factor is four to the power of the select field
	function automatic logic [15:0] prescaleValue(input logic [1:0] sel);
		prescaleValue = 16'h0001 << {sel, 1'b0};
	endfunction

	twbpe_state_t state_q, state_d;
	logic [1:0] phase_q, phase_d;
	logic [15:0] timer_q, timer_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] shift_q, shift_d, code_q, code_d, status_q, rxData_q, rxData_d;
	logic sdaLow_q, sdaLow_d, sclLow_q, sclLow_d;
	logic master_q, master_d, addressed_q, addressed_d, addrPhase_q, addrPhase_d;
	logic txMode_q, txMode_d, dirRead_q, dirRead_d, busy_q, busy_d;
	logic arbLost_q, arbLost_d, gcall_q, gcall_d, flag_q, setFlag;
	logic sclMeta_q, sclSync_q, sclPrev_q, sdaMeta_q, sdaSync_q, sdaPrev_q;

	wire logic sclRise = sclSync_q & ~sclPrev_q;
	wire logic sclFall = ~sclSync_q & sclPrev_q;
	// Bus conditions are SDA edges while SCL stays high
	wire logic startDet = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q; // see RULE10
	wire logic stopDet = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q; // see RULE10
	wire logic [15:0] rateTerm = 16'({8'h00, bitRateDivider} * prescaleValue(ratePrescaleSelect));
	wire logic [15:0] halfCycles = `TWBPE_HALF_BASE + rateTerm; // see RULE23
	wire logic halfDone = timer_q >= halfCycles - 16'h0001;
	wire logic ownMatch = shift_q[7:1] == ownAddr.address; // see RULE25
	wire logic gcMatch = ownAddr.generalCallAccept & (shift_q[7:1] == `TWBPE_GCALL_ADDR)
		& ~shift_q[0]; // see RULE14
	wire logic slaveSide = (state_q == ST_IDLE) | (state_q == ST_SLAVE)
		| ((state_q == ST_HOLD) & ~master_q);
	wire logic midByte = (state_q == ST_SLAVE) & (bitCnt_q != 4'd0);

	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		code_d = code_q;
		rxData_d = rxData_q;
		sdaLow_d = sdaLow_q;
		sclLow_d = sclLow_q;
		master_d = master_q;
		addressed_d = addressed_q;
		addrPhase_d = addrPhase_q;
		txMode_d = txMode_q;
		dirRead_d = dirRead_q;
		arbLost_d = arbLost_q;
		gcall_d = gcall_q;
		busy_d = (busy_q | startDet) & ~stopDet; // see RULE11
		setFlag = 1'b0;
		case (state_q)
			ST_IDLE: begin
				sdaLow_d = 1'b0;
				sclLow_d = 1'b0;
				if (ctrlWrite & ctrl.startReq) begin
					state_d = ST_START;
					phase_d = 2'd0;
				end
			end
			ST_START: begin
				case (phase_q)
					2'd0: begin
						sdaLow_d = 1'b0;
						// A slave-side START waits until the bus is free
						if (halfDone & (master_q | ~busy_q)) begin // see RULE10
							phase_d = 2'd1;
							sclLow_d = 1'b0;
						end
					end
					2'd1: begin
						if (sclSync_q & sdaSync_q & halfDone & (master_q | ~busy_q)) begin
							phase_d = 2'd2;
							sdaLow_d = 1'b1;
						end
					end
					default: begin
						if (halfDone) begin
							sclLow_d = 1'b1;
							setFlag = 1'b1; // see RULE4
							code_d = master_q ? `TWBPE_ST_REPSTART : `TWBPE_ST_START;
							master_d = 1'b1;
							addrPhase_d = 1'b1;
							state_d = ST_HOLD;
						end
					end
				endcase
			end
			ST_LOW: begin
				sclLow_d = 1'b1;
				// Data moves only once SCL is seen low
				if (~sclSync_q) begin // see RULE9
					sdaLow_d = (bitCnt_q == `TWBPE_BITS_PER_BYTE) ? (~txMode_q & ctrl.ackEnable)
						: (txMode_q & ~shift_q[7]); // see RULE16
				end
				if (halfDone & ~sclSync_q) begin // see RULE19
					sclLow_d = 1'b0;
					state_d = ST_HIGH;
				end
			end
			ST_HIGH: begin
				sclLow_d = 1'b0;
				if (sclRise) begin // see RULE18
					shift_d = {shift_q[6:0], sdaSync_q};
					bitCnt_d = bitCnt_q + 4'd1;
					// Catch a read byte on its eighth bit, before the ack bit shifts it out
					if (dirRead_q & ~addrPhase_q & (bitCnt_q == 4'd7)) begin // see RULE12
						rxData_d = {shift_q[6:0], sdaSync_q};
					end
					if (txMode_q & (bitCnt_q < `TWBPE_BITS_PER_BYTE) & ~sdaLow_q & ~sdaSync_q) begin
						master_d = 1'b0; // see RULE20
						arbLost_d = 1'b1;
						sdaLow_d = 1'b0; // see RULE21
						txMode_d = 1'b0;
						state_d = ST_SLAVE;
					end
				end else if ((halfDone & sclSync_q) | sclFall) begin // see RULE19
					sclLow_d = 1'b1;
					if (bitCnt_q == `TWBPE_BITS_PER_PACKET) begin
						setFlag = 1'b1; // see RULE4
						if (addrPhase_q) begin
							code_d = (dirRead_q ? `TWBPE_ST_MR_ADDR : `TWBPE_ST_MT_ADDR) | {7'h00, shift_q[0]};
						end else begin
							code_d = (dirRead_q ? `TWBPE_ST_MR_DATA : `TWBPE_ST_MT_DATA) | {7'h00, shift_q[0]};
						end
						addrPhase_d = 1'b0;
						sdaLow_d = 1'b0;
						state_d = ST_HOLD;
					end else begin
						state_d = ST_LOW;
					end
				end
			end
			ST_SLAVE: begin
				sclLow_d = 1'b0;
				if (sclRise) begin
					shift_d = {shift_q[6:0], sdaSync_q};
					bitCnt_d = bitCnt_q + 4'd1;
				end else if (sclFall) begin
					if (bitCnt_q == `TWBPE_BITS_PER_BYTE) begin
						if (addrPhase_q) begin
							addressed_d = ownMatch | gcMatch; // see RULE6
							gcall_d = gcMatch;
							txMode_d = ownMatch & shift_q[0];
							sdaLow_d = (ownMatch | gcMatch) & ctrl.ackEnable; // see RULE13
						end else begin
							sdaLow_d = addressed_q & ~txMode_q & ctrl.ackEnable; // see RULE16
							rxData_d = shift_q;
						end
						if (~(addrPhase_q & (ownMatch | gcMatch)) & ~addressed_q) begin
							sdaLow_d = 1'b0;
							arbLost_d = 1'b0;
							setFlag = arbLost_q; // see RULE5
							code_d = `TWBPE_ST_ARBLOST;
							state_d = arbLost_q ? ST_HOLD : ST_IDLE;
						end
					end else if (bitCnt_q == `TWBPE_BITS_PER_PACKET) begin
						setFlag = 1'b1; // see RULE6
						sdaLow_d = 1'b0;
						if (addrPhase_q) begin
							code_d = gcall_q ? `TWBPE_ST_SR_GCALL
								: (txMode_q ? `TWBPE_ST_ST_ADDR : `TWBPE_ST_SR_ADDR);
						end else begin
							code_d = txMode_q ? (`TWBPE_ST_ST_DATA | {7'h00, shift_q[0]}) : `TWBPE_ST_SR_DATA;
						end
						addrPhase_d = 1'b0;
						arbLost_d = 1'b0;
						state_d = ST_HOLD;
					end else begin
						sdaLow_d = txMode_q & ~shift_q[7]; // see RULE9
					end
				end
			end
			ST_HOLD: begin
				// Stretch only once the line is already low, never cut a high phase short
				sclLow_d = (master_q | addressed_q) & (sclLow_q | ~sclSync_q); // see RULE3
				if (ctrlWrite & flag_q) begin // see RULE24
					bitCnt_d = 4'd0;
					shift_d = txData;
					phase_d = 2'd0;
					if (ctrl.startReq) begin
						state_d = ST_START;
					end else if (ctrl.stopReq & master_q & ~addrPhase_q) begin // see RULE17
						state_d = ST_STOP;
					end else if (master_q) begin
						state_d = ST_LOW; // see RULE12
						txMode_d = addrPhase_q | ~dirRead_q;
						dirRead_d = addrPhase_q ? txData[0] : dirRead_q;
					end else if (addressed_q) begin
						state_d = ST_SLAVE;
						sclLow_d = 1'b0;
						sdaLow_d = txMode_q & ~txData[7];
					end else begin
						state_d = ST_IDLE;
						sclLow_d = 1'b0;
					end
				end
			end
			ST_STOP: begin
				case (phase_q)
					2'd0: begin
						sclLow_d = 1'b1;
						sdaLow_d = 1'b1;
						if (halfDone) begin
							phase_d = 2'd1;
							sclLow_d = 1'b0;
						end
					end
					2'd1: begin
						if (sclSync_q & halfDone) begin // see RULE18
							phase_d = 2'd2;
							sdaLow_d = 1'b0;
						end
					end
					default: begin
						if (halfDone) begin
							master_d = 1'b0;
							state_d = ST_IDLE;
						end
					end
				endcase
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if ((startDet | stopDet) & slaveSide) begin
			if (addressed_q) begin
				setFlag = 1'b1; // see RULE7
				code_d = `TWBPE_ST_SR_STOP;
			end else if (midByte) begin
				setFlag = 1'b1; // see RULE8
				code_d = `TWBPE_ST_BUSERR;
			end
			addressed_d = 1'b0;
			txMode_d = 1'b0;
			sdaLow_d = 1'b0;
			sclLow_d = 1'b0;
			bitCnt_d = 4'd0;
			addrPhase_d = startDet;
			state_d = startDet ? ST_SLAVE : ST_IDLE;
		end else if ((startDet | stopDet) & master_q
			& ((state_q == ST_LOW) | (state_q == ST_HIGH))) begin
			setFlag = 1'b1; // see RULE8
			code_d = `TWBPE_ST_BUSERR;
			master_d = 1'b0;
			sdaLow_d = 1'b0;
			sclLow_d = 1'b0;
			state_d = ST_HOLD;
		end
	end

	// Half-period timer restarts at every observed SCL edge and every step
	always_comb begin
		if (sclRise | sclFall | (state_d != state_q) | (phase_d != phase_q)) begin // see RULE19
			timer_d = 16'h0000;
		end else if (timer_q == 16'hffff) begin
			timer_d = timer_q;
		end else begin
			timer_d = timer_q + 16'h0001;
		end
	end

	// Pins pass two flip-flops; only the second stage and its delayed copy are read
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			{sclMeta_q, sclSync_q, sclPrev_q} <= 3'b111; // see RULE26
			{sdaMeta_q, sdaSync_q, sdaPrev_q} <= 3'b111;
		end else begin
			{sclMeta_q, sclSync_q, sclPrev_q} <= {sclIn, sclMeta_q, sclSync_q};
			{sdaMeta_q, sdaSync_q, sdaPrev_q} <= {sdaIn, sdaMeta_q, sdaSync_q};
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE; // see RULE27
			{phase_q, bitCnt_q, timer_q} <= '0;
			{shift_q, rxData_q} <= '0;
			code_q <= `TWBPE_ST_NOINFO;
			status_q <= `TWBPE_ST_NOINFO;
			{sdaLow_q, sclLow_q, master_q, addressed_q, addrPhase_q} <= '0;
			{txMode_q, dirRead_q, busy_q, arbLost_q, gcall_q, flag_q} <= '0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			bitCnt_q <= bitCnt_d;
			timer_q <= timer_d;
			shift_q <= shift_d;
			rxData_q <= rxData_d;
			code_q <= code_d;
			// Status trails the flag by one clock in both directions
			status_q <= flag_q ? code_q : `TWBPE_ST_NOINFO; // see RULE1, see RULE2
			{sdaLow_q, sclLow_q, master_q, addressed_q, addrPhase_q} <=
				{sdaLow_d, sclLow_d, master_d, addressed_d, addrPhase_d};
			{txMode_q, dirRead_q, busy_q, arbLost_q, gcall_q} <=
				{txMode_d, dirRead_d, busy_d, arbLost_d, gcall_d};
			// A new event in the clearing cycle keeps the flag set
			flag_q <= setFlag | (flag_q & ~ctrlWrite); // see RULE24
		end
	end

	assign eventPendingFlag = flag_q;
	assign busStatusCode = status_q;
	assign rxData = rxData_q;
	assign sclOut = 1'b0; // see RULE26
	assign sdaOut = 1'b0;
	assign sclOe = sclLow_q;
	assign sdaOe = sdaLow_q;

endmodule

`default_nettype wire

// >>> verification/twbpe_engine_props.sv
// Concurrent checks on the protocol engine's event flag, status code and line enables.
// Assumes one clock domain and the async active-low reset seen at the ports.
`timescale 1ns/1ps
`default_nettype none
module twbpe_engine_props (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ctrlWrite,
	input wire logic eventPendingFlag,
	input wire logic [7:0] busStatusCode,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaOut,
	input wire logic sdaOe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Arbitration loss, bus error and stop-while-addressed flags leave the bus free
	wire logic holdsBus = !(busStatusCode inside {8'h00, 8'h18, 8'h3c});
	wire logic flagOld = eventPendingFlag && holdsBus;
	property p_code_lag;
		$rose(eventPendingFlag) |=> busStatusCode != 8'hff;
	endproperty
	a_code_lag: assert property (p_code_lag) else $error("status not loaded after flag");
	property p_no_info;
		!eventPendingFlag && !$past(eventPendingFlag) |-> busStatusCode == 8'hff;
	endproperty
	a_no_info: assert property (p_no_info) else $error("status shown without flag");
	property p_code_held;
		eventPendingFlag && $past(eventPendingFlag) && !ctrlWrite |=> $stable(busStatusCode);
	endproperty
	a_code_held: assert property (p_code_held) else $error("status moved under flag");
	property p_scl_stall;
		flagOld && $past(eventPendingFlag) && $past(eventPendingFlag, 2) |-> sclOe;
	endproperty
	a_scl_stall: assert property (p_scl_stall) else $error("SCL free while flag set");
	property p_open_drain;
		sclOut == 1'b0 && sdaOut == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	property p_clear;
		ctrlWrite && eventPendingFlag |=> !eventPendingFlag;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared by write");
	property p_quiet;
		flagOld && $past(eventPendingFlag, 2) && !ctrlWrite |=> $stable(sdaOe) && $stable(sclOe);
	endproperty
	a_quiet: assert property (p_quiet) else $error("bus moved while flag set");
	property p_reset_state;
		$rose(nrst) |-> !eventPendingFlag && busStatusCode == 8'hff && !sclOe && !sdaOe;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
	c_data_sent: cover property ($rose(eventPendingFlag) ##1 busStatusCode == 8'h14);
	c_addressed: cover property ($rose(eventPendingFlag) ##1 busStatusCode == 8'h30);
	c_arb_lost: cover property ($rose(eventPendingFlag) ##1 busStatusCode == 8'h18);
endmodule
bind twbpe_engine twbpe_engine_props u_props (.ref_clk(ref_clk), .nrst(nrst),
	.ctrlWrite(ctrlWrite), .eventPendingFlag(eventPendingFlag), .busStatusCode(busStatusCode),
	.sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

// >>> verification/twbpe_bus_peer.sv
// Behavioural slave on the bus: acks its address and later bytes, stretches SCL before ack.
// Assumes wired-AND lines from the bench; works on the falling clock edge to avoid races.
`timescale 1ns/1ps
`default_nettype none
module twbpe_bus_peer #(parameter logic [6:0] ADDR = 7'h2a) (
	input wire logic ref_clk,
	input wire logic sclW,
	input wire logic sdaW,
	input wire logic [3:0] stretch,
	output logic sclOe,
	output logic sdaOe,
	output logic [7:0] rxByte
);
	logic sclP = 1'b1, sdaP = 1'b1, sel = 1'b0;
	logic [3:0] bits = 4'h0, hold = 4'h0;
	logic [7:0] sh = 8'h00;
	initial begin
		sclOe = 1'b0;
		sdaOe = 1'b0;
		rxByte = 8'h00;
	end
	always @(negedge ref_clk) begin
		sclP <= sclW;
		sdaP <= sdaW;
		if (sclW && sclP && sdaP && !sdaW) begin
			bits <= 4'h0;
			sel <= 1'b0;
		end
		if (sclW && !sclP) begin
			sh <= {sh[6:0], sdaW};
			bits <= bits + 4'h1;
		end
		if (!sclW && sclP) begin
			sdaOe <= 1'b0;
			if (bits == 4'h8 && (sel || sh[7:1] == ADDR)) begin
				sdaOe <= 1'b1;
				sel <= 1'b1;
				rxByte <= sh;
				hold <= stretch;
				sclOe <= stretch != 4'h0;
			end
			if (bits == 4'h9)
				bits <= 4'h0;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
			sclOe <= hold != 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> verification/twbpe_engine_test.sv
// Self-checking bench: engine as master against the peer model, and as slave against a
// bit-banged master of its own. Status codes go through a queue checked on each flag.
`timescale 1ns/1ps
`default_nettype none
module twbpe_engine_test;
	import twbpe_pkg::*;
	localparam int H = 20;
	logic ref_clk = 1'b0, nrst = 1'b0, ctrlWrite = 1'b0, mScl = 1'b0, mSda = 1'b0;
	twbpe_ctrl_t ctrl = '{1'b0, 1'b0, 1'b1};
	twbpe_addr_t ownAddr = '{7'h51, 1'b0};
	logic [7:0] txData = 8'h00, bitRateDivider = 8'h00, busStatusCode, rxData, pRx;
	logic [1:0] ratePrescaleSelect = 2'h0;
	logic [3:0] stretch = 4'hf;
	logic eventPendingFlag, sclOut, sclOe, sdaOut, sdaOe, pSclOe, pSdaOe;
	wire logic sclW = !(sclOe || pSclOe || mScl);
	wire logic sdaW = !(sdaOe || pSdaOe || mSda);
	int err_total = 0, tests_run = 0, cyc = 0;
	integer seed = 32'h239e7896;
	logic [7:0] expQ[$];
	twbpe_engine DUT (.ref_clk(ref_clk), .nrst(nrst), .ctrlWrite(ctrlWrite), .ctrl(ctrl),
		.txData(txData), .ownAddr(ownAddr), .bitRateDivider(bitRateDivider),
		.ratePrescaleSelect(ratePrescaleSelect), .eventPendingFlag(eventPendingFlag),
		.busStatusCode(busStatusCode), .rxData(rxData), .sclIn(sclW), .sclOut(sclOut),
		.sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe));
	twbpe_bus_peer u_peer (.ref_clk(ref_clk), .sclW(sclW), .sdaW(sdaW), .stretch(stretch),
		.sclOe(pSclOe), .sdaOe(pSdaOe), .rxByte(pRx));
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One software command; e is the code its flag should bring, ff for none
	task automatic cmd(input logic s, input logic p, input logic [7:0] d, input logic [7:0] e);
		@(negedge ref_clk);
		ctrl = '{s, p, 1'b1};
		txData = d;
		ctrlWrite = 1'b1;
		if (e != 8'hff)
			expQ.push_back(e);
		@(negedge ref_clk);
		ctrlWrite = 1'b0;
	endtask
	task automatic waitFlag();
		int n;
		n = 0;
		while (eventPendingFlag !== 1'b1 && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
		chk("flag raised", 8'h01, {7'h0, eventPendingFlag});
		@(negedge ref_clk);
	endtask
	initial forever begin
		@(posedge eventPendingFlag);
		@(posedge ref_clk);
		#1;
		if (expQ.size() == 0)
			chk("event count", 8'h00, 8'h01);
		else
			chk("status code", expQ.pop_front(), busStatusCode);
	end
	// Bench master bit: data set while SCL low, then waits out any stretching
	task automatic mBit(input logic b, output logic r);
		int n;
		// Let SCL settle low before SDA moves
		@(negedge ref_clk);
		mSda = !b;
		repeat (H) @(negedge ref_clk);
		mScl = 1'b0;
		n = 0;
		while (!sclW && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		r = sdaW;
		repeat (H) @(negedge ref_clk);
		mScl = 1'b1;
	endtask
	task automatic mByte(input logic [7:0] b, input logic ackLvl);
		logic r;
		for (int i = 7; i >= 0; i--)
			mBit(b[i], r);
		mBit(1'b1, r);
		chk("ack level", {7'h0, ackLvl}, {7'h0, r});
	endtask
	task automatic mStart();
		mSda = 1'b1;
		repeat (H) @(negedge ref_clk);
		mScl = 1'b1;
	endtask
	task automatic mStop();
		@(negedge ref_clk);
		mSda = 1'b1;
		repeat (H) @(negedge ref_clk);
		mScl = 1'b0;
		repeat (H) @(negedge ref_clk);
		mSda = 1'b0;
		repeat (H) @(negedge ref_clk);
	endtask
	initial begin
		logic r;
		logic [7:0] d;
		int t0, hp;
		repeat (20) @(negedge ref_clk);
		chk("held in reset", 8'h0f, {eventPendingFlag, sclOe, sdaOe, 5'h0f});
		nrst = 1'b1;
		bitRateDivider = 8'({$random(seed)} % 8);
		ratePrescaleSelect = 2'({$random(seed)} % 2);
		cmd(1'b1, 1'b0, 8'h00, 8'h08);
		waitFlag();
		cmd(1'b0, 1'b0, {7'h2a, 1'b0}, 8'h10);
		waitFlag();
		chk("peer address", 8'h54, pRx);
		d = 8'($random(seed));
		cmd(1'b0, 1'b0, d, 8'h14);
		@(posedge sclW);
		@(posedge sclW);
		t0 = cyc;
		@(posedge sclW);
		hp = 16 + 2 * int'(bitRateDivider) * (4 ** int'(ratePrescaleSelect));
		chk("scl period", 8'h01, {7'h0, cyc - t0 >= hp && cyc - t0 <= hp + 8});
		waitFlag();
		chk("peer data", d, pRx);
		cmd(1'b1, 1'b0, 8'h00, 8'h0c);
		waitFlag();
		cmd(1'b0, 1'b0, {7'h33, 1'b0}, 8'h11);
		waitFlag();
		cmd(1'b0, 1'b1, 8'h00, 8'hff);
		repeat (300) @(negedge ref_clk);
		chk("lines idle after stop", 8'h03, {6'h0, sclW, sdaW});
		ownAddr = '{7'h51, 1'b1};
		mStart();
		expQ.push_back(8'h30);
		mByte({7'h51, 1'b0}, 1'b0);
		waitFlag();
		cmd(1'b0, 1'b0, 8'h00, 8'hff);
		d = 8'($random(seed));
		expQ.push_back(8'h38);
		mByte(d, 1'b0);
		waitFlag();
		chk("received byte", d, rxData);
		cmd(1'b0, 1'b0, 8'h00, 8'hff);
		expQ.push_back(8'h3c);
		mStop();
		waitFlag();
		cmd(1'b0, 1'b0, 8'h00, 8'hff);
		for (int i = 0; i < 3; i++) begin
			ownAddr = '{7'h51, i == 2};
			mStart();
			if (i == 2)
				expQ.push_back(8'h34);
			mByte({(i == 0) ? 7'h52 : 7'h00, 1'b0}, i != 2);
			if (i == 2) begin
				waitFlag();
				cmd(1'b0, 1'b0, 8'h00, 8'h3c);
			end
			mStop();
			if (i == 2)
				waitFlag();
			cmd(1'b0, 1'b0, 8'h00, 8'hff);
		end
		mStart();
		repeat (3) mBit(1'b1, r);
		expQ.push_back(8'h00);
		mStop();
		waitFlag();
		cmd(1'b0, 1'b0, 8'h00, 8'hff);
		ownAddr = '{7'h51, 1'b0};
		cmd(1'b1, 1'b0, 8'h00, 8'h08);
		waitFlag();
		// A rival holds SDA low over the engine's first address bit
		mSda = 1'b1;
		cmd(1'b0, 1'b0, 8'hfe, 8'h18);
		// The loser stops clocking; the flag only comes at the end of the address
		repeat (150) @(negedge ref_clk);
		chk("sda released after loss", 8'h00, {7'h0, sdaOe});
		mScl = 1'b1;
		repeat (7) mBit(1'b0, r);
		mBit(1'b1, r);
		waitFlag();
		cmd(1'b0, 1'b0, 8'h00, 8'hff);
		chk("no ack after loss", 8'h01, {7'h0, r});
		mStop();
		repeat (50) @(negedge ref_clk);
		chk("queue drained", 8'h00, 8'(expQ.size()));
		tally_and_finish();
	end
	// Whole run needs well under this; a stall anywhere ends here as a failure
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_total++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
